// ===== verilog/lfsr_loop_regs.v
// loop, status extension and fast interrupt state registers
`timescale 1ns/1ps
`include "lfsr_defs.vh"
module lfsr_loop_regs
(
	input wire clk,
	input wire nrst,
	// move port, same clock as the core
	input wire mvWrite,
	input wire mvRead,
	input wire [2:0] mvSel,
	input wire mvLong,
	input wire [31:0] mvWdata,
	output wire [31:0] mvRdata,
	// core state inputs
	input wire [15:0] pcLow,
	input wire [4:0] pcHigh,
	input wire pcLoad,
	input wire [7:0] ccrIn,
	input wire ccrLoad,
	input wire [15:0] operatingModeWord,
	input wire stackPointerLowBit,
	// loop control
	input wire loopStartCount,
	input wire [15:0] loopCountIn,
	input wire [23:0] loopEndIn,
	input wire loopStartFromCounter,
	input wire singleInstructionRepeat,
	input wire loopLastInstr,
	input wire nestDone,
	// subroutine and interrupt flow
	input wire subroutineCall,
	input wire subroutineReturn,
	input wire [15:0] stackedStatus,
	input wire fastIrqEnter,
	input wire fastIrqExit,
	// outputs
	output wire [15:0] coreStatusWord,
	output wire [20:0] programAddress,
	output wire [15:0] pushStatus,
	output wire pushValid,
	output wire [15:0] loopCounter,
	output wire [23:0] loopEndAddress,
	output wire loopEnd,
	output wire [23:0] hwStackTop,
	output wire [12:0] fastIrqStateSnapshot,
	output wire [20:0] fastIrqReturnAddress,
	output wire restoreValid
);
	// ============================================================
	// reset release
	wire rstN; // synchronised reset
	lfsr_sync uSync
	(
		.clk(clk),
		.nrstIn(nrst),
		.nrstOut(rstN)
	);

	// ============================================================
	// state registers
	reg [15:0] sr_q; // core status word
	reg [15:0] sr_d;
	reg [15:0] lc_q; // loop counter
	reg [15:0] lc_d;
	reg [15:0] lc2_q; // counter backup
	reg [15:0] lc2_d;
	reg [23:0] la_q; // loop end address
	reg [23:0] la_d;
	reg [23:0] la2_q; // end address backup
	reg [23:0] la2_d;
	reg [23:0] hws0_q; // stack top entry
	reg [23:0] hws0_d;
	reg [23:0] hws1_q; // second entry, no software path
	reg [23:0] hws1_d;
	reg [31:0] rdata_q; // read data register
	reg [31:0] rdata_d;
	reg push_q; // status push strobe
	reg restore_q; // fast exit strobe
	reg loopEnd_q; // loop terminated strobe

	wire nlBit = operatingModeWord[`LFSR_OMR_NL]; // nested looping bit
	wire wrSel = mvWrite; // any move write
	wire loopStart = loopStartCount | loopStartFromCounter;
	wire lastHit = loopLastInstr & ~singleInstructionRepeat;
	wire termNow = lastHit & (lc_q == 16'h0001);
	wire [23:0] wr24 = mvWdata[23:0];

	// ============================================================
	// fast interrupt holding registers, not reset
	wire [12:0] snapIn;
	wire [12:0] snapLoad; // software or entry value
	wire [20:0] firaLoad;
	assign snapIn = {stackPointerLowBit, sr_q[`LFSR_SR_LF], nlBit,
		sr_q[`LFSR_SR_IM_HI:`LFSR_SR_IM_LO], sr_q[`LFSR_SNAP_CCR_HI:0]};
	assign snapLoad = fastIrqEnter ? snapIn : mvWdata[12:0];
	assign firaLoad = fastIrqEnter ? {sr_q[`LFSR_SR_PCX_HI:`LFSR_SR_PCX_LO], pcLow}
		: mvWdata[20:0];
	lfsr_wreg #(.WIDTH(13)) uSnap
	(
		.clk(clk),
		.load(fastIrqEnter | (wrSel & (mvSel == `LFSR_SEL_FAST_IRQ_STATE_SNAPSHOT))),
		.dIn(snapLoad),
		.qOut(fastIrqStateSnapshot)
	);
	lfsr_wreg #(.WIDTH(21)) uFira
	(
		.clk(clk),
		.load(fastIrqEnter | (wrSel & (mvSel == `LFSR_SEL_FAST_IRQ_RETURN_ADDRESS))),
		.dIn(firaLoad),
		.qOut(fastIrqReturnAddress)
	);

	// ============================================================
	// next state of the status word and loop registers
	always @*
	begin
		sr_d = sr_q;
		lc_d = lc_q;
		lc2_d = lc2_q;
		la_d = la_q;
		la2_d = la2_q;
		hws0_d = hws0_q;
		hws1_d = hws1_q;
		// condition flags from the data path
		if (ccrLoad)
		begin
			sr_d[7:0] = ccrIn;
		end
		// software move writes
		if (wrSel)
		begin
			case (mvSel)
				`LFSR_SEL_SR:
				begin
					// extension bits kept
					sr_d = {mvWdata[15], sr_q[14:10], mvWdata[9:0]};
				end
				`LFSR_SEL_LC:
				begin
					lc_d = mvWdata[15:0];
					lc2_d = lc_q;
				end
				`LFSR_SEL_LC2: lc2_d = mvWdata[15:0];
				`LFSR_SEL_LA: la_d = mvLong ? wr24 : {8'h00, mvWdata[15:0]};
				`LFSR_SEL_LA2: la2_d = wr24;
				`LFSR_SEL_HWS:
				begin
					// push onto top only
					hws1_d = hws0_q;
					hws0_d = mvLong ? wr24 : {8'h00, mvWdata[15:0]};
					sr_d[`LFSR_SR_LF] = 1'b1;
				end
				default: sr_d = sr_d; // snapshot and return handled apart
			endcase
		end
		// stack read pops top
		if (mvRead && mvSel == `LFSR_SEL_HWS)
		begin
			hws0_d = hws1_q;
			sr_d[`LFSR_SR_LF] = nlBit;
		end
		// loop start
		if (loopStart)
		begin
			la2_d = la_q;
			sr_d[`LFSR_SR_LF] = 1'b1;
			if (loopStartCount)
			begin
				lc2_d = lc_q;
				lc_d = loopCountIn;
				la_d = loopEndIn;
			end
		end
		else if (lastHit)
		begin
			if (termNow)
			begin
				sr_d[`LFSR_SR_LF] = nlBit;
				if (nlBit)
				begin
					lc_d = lc2_q;
				end
			end
			else
			begin
				lc_d = lc_q - 16'h0001;
			end
		end
		// nested loop finished
		if (nestDone)
		begin
			la_d = la2_q;
		end
		// program counter jump
		if (pcLoad)
		begin
			sr_d[`LFSR_SR_PCX_HI:`LFSR_SR_PCX_LO] = pcHigh;
		end
		// returns restore extension from stack
		if (subroutineReturn)
		begin
			sr_d[`LFSR_SR_PCX_HI:`LFSR_SR_PCX_LO] =
				stackedStatus[`LFSR_SR_PCX_HI:`LFSR_SR_PCX_LO];
		end
		// fast exit restores flags
		if (fastIrqExit)
		begin
			sr_d[`LFSR_SR_LF] = fastIrqStateSnapshot[`LFSR_SNAP_LF];
			sr_d[9:0] = fastIrqStateSnapshot[9:0];
			sr_d[`LFSR_SR_PCX_HI:`LFSR_SR_PCX_LO] = fastIrqReturnAddress[20:16];
		end
	end

	// ============================================================
	// read mux
	always @*
	begin
		case (mvSel)
			`LFSR_SEL_SR: rdata_d = {16'h0000, sr_q};
			`LFSR_SEL_LC: rdata_d = {16'h0000, lc_q};
			`LFSR_SEL_LC2: rdata_d = {16'h0000, lc2_q};
			`LFSR_SEL_LA: rdata_d = {8'h00, la_q};
			`LFSR_SEL_LA2: rdata_d = {8'h00, la2_q};
			`LFSR_SEL_HWS: rdata_d = {8'h00, hws0_q};
			`LFSR_SEL_FAST_IRQ_STATE_SNAPSHOT: rdata_d = {19'h00000, fastIrqStateSnapshot};
			`LFSR_SEL_FAST_IRQ_RETURN_ADDRESS: rdata_d = {11'h000, fastIrqReturnAddress};
			default: rdata_d = 32'h00000000;
		endcase
		if (!mvLong)
		begin
			rdata_d[31:16] = 16'h0000;
		end
	end

	// ============================================================
	// clocked state; reset clears flags and sets interrupt mask
	always @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			sr_q <= `LFSR_SR_RST;
			lc_q <= `LFSR_LC_RST;
			lc2_q <= `LFSR_LC_RST;
			la_q <= `LFSR_LA_RST;
			la2_q <= `LFSR_LA_RST;
			hws0_q <= `LFSR_LA_RST;
			hws1_q <= `LFSR_LA_RST;
			rdata_q <= 32'h00000000;
			push_q <= 1'b0;
			restore_q <= 1'b0;
			loopEnd_q <= 1'b0;
		end
		else
		begin
			sr_q <= sr_d;
			lc_q <= lc_d;
			lc2_q <= lc2_d;
			la_q <= la_d;
			la2_q <= la2_d;
			hws0_q <= hws0_d;
			hws1_q <= hws1_d;
			if (mvRead)
			begin
				rdata_q <= rdata_d;
			end
			push_q <= subroutineCall;
			restore_q <= fastIrqExit;
			loopEnd_q <= termNow & ~loopStart;
		end
	end

	// ============================================================
	// outputs
	assign coreStatusWord = sr_q;
	assign programAddress = {sr_q[`LFSR_SR_PCX_HI:`LFSR_SR_PCX_LO], pcLow};
	assign pushStatus = sr_q;
	assign pushValid = push_q;
	assign loopCounter = lc_q;
	assign loopEndAddress = la_q;
	assign loopEnd = loopEnd_q;
	assign hwStackTop = hws0_q;
	assign mvRdata = rdata_q;
	assign restoreValid = restore_q;
endmodule // lfsr_loop_regs

// ===== inc/lfsr_defs.vh
// constants for the loop and fast interrupt state registers
`ifndef LFSR_DEFS_VH
`define LFSR_DEFS_VH
// ============================================================
// status word field positions
`define LFSR_SR_PCX_LO 10
`define LFSR_SR_PCX_HI 14
`define LFSR_SR_LF 15
`define LFSR_SR_IM_LO 8
`define LFSR_SR_IM_HI 9
// operating mode word nested looping bit
`define LFSR_OMR_NL 15
// ============================================================
// snapshot field positions
`define LFSR_SNAP_SPL 12
`define LFSR_SNAP_LF 11
`define LFSR_SNAP_NL 10
`define LFSR_SNAP_IM_LO 8
`define LFSR_SNAP_IM_HI 9
`define LFSR_SNAP_CCR_HI 7
// ============================================================
// reset values
`define LFSR_SR_RST 16'h0300
`define LFSR_LC_RST 16'h0000
`define LFSR_LA_RST 24'h000000
// ============================================================
// register selects of the move port
`define LFSR_SEL_SR 3'h0
`define LFSR_SEL_LC 3'h1
`define LFSR_SEL_LC2 3'h2
`define LFSR_SEL_LA 3'h3
`define LFSR_SEL_LA2 3'h4
`define LFSR_SEL_HWS 3'h5
`define LFSR_SEL_FAST_IRQ_STATE_SNAPSHOT 3'h6
`define LFSR_SEL_FAST_IRQ_RETURN_ADDRESS 3'h7
`endif

// ===== verilog/lfsr_sync.v
// two flip-flop reset release synchroniser
`timescale 1ns/1ps
module lfsr_sync
(
	input wire clk,
	input wire nrstIn,
	output wire nrstOut
);
	// ============================================================
	// release chain
	reg stage1_q; // first stage, read only by second
	reg stage2_q; // synchronised copy
	// assert async, release on clock
	always @(posedge clk or negedge nrstIn)
	begin
		if (!nrstIn)
		begin
			stage1_q <= 1'b0;
			stage2_q <= 1'b0;
		end
		else
		begin
			stage1_q <= 1'b1;
			stage2_q <= stage1_q;
		end
	end
	assign nrstOut = stage2_q;
endmodule // lfsr_sync

// ===== verilog/lfsr_wreg.v
// width-parameterised clocked holding register with load enable
`timescale 1ns/1ps
module lfsr_wreg
#(
	parameter WIDTH = 16
)
(
	input wire clk,
	input wire load,
	input wire [WIDTH-1:0] dIn,
	output wire [WIDTH-1:0] qOut
);
	// ============================================================
	// storage without reset, keeps value across processor reset
	reg [WIDTH-1:0] val_q; // held value
	// load on enable
	always @(posedge clk)
	begin
		if (load)
		begin
			val_q <= dIn;
		end
	end
	assign qOut = val_q;
endmodule // lfsr_wreg

// ===== dv/lfsr_loop_regs_assertions.sv
// checker for the loop and fast interrupt state registers
`timescale 1ns/1ps
module lfsr_loop_regs_chk
(
	input wire clk,
	input wire nrst,
	input wire mvWrite,
	input wire [2:0] mvSel,
	input wire [15:0] pcLow,
	input wire [4:0] pcHigh,
	input wire pcLoad,
	input wire [15:0] operatingModeWord,
	input wire stackPointerLowBit,
	input wire loopStartCount,
	input wire [15:0] loopCountIn,
	input wire [23:0] loopEndIn,
	input wire loopStartFromCounter,
	input wire singleInstructionRepeat,
	input wire loopLastInstr,
	input wire subroutineCall,
	input wire subroutineReturn,
	input wire fastIrqEnter,
	input wire fastIrqExit,
	input wire [15:0] coreStatusWord,
	input wire [20:0] programAddress,
	input wire pushValid,
	input wire [15:0] loopCounter,
	input wire [23:0] loopEndAddress,
	input wire loopEnd,
	input wire [12:0] fastIrqStateSnapshot,
	input wire [20:0] fastIrqReturnAddress,
	input wire restoreValid
);
// ============================================================
// shared terms
default clocking @(posedge clk); endclocking
default disable iff (!nrst);
// loop test taken, nothing else touching the counter
wire lastOk = loopLastInstr && !singleInstructionRepeat && !loopStartCount
	&& !loopStartFromCounter && !mvWrite;
// ============================================================
// properties
pc_address_a: assert property (pcLoad && !subroutineReturn && !fastIrqExit
	|=> programAddress == {$past(pcHigh), pcLow}) else $error("program address mismatch");
ext_locked_a: assert property (mvWrite && mvSel == 3'h0 && !pcLoad && !subroutineReturn
	&& !fastIrqExit |=> $stable(coreStatusWord[14:10])) else $error("extension changed");
flag_set_a: assert property ((loopStartCount || loopStartFromCounter) && !mvWrite
	&& !fastIrqExit |=> coreStatusWord[15]) else $error("loop flag not set");
flag_end_a: assert property (loopEnd |-> coreStatusWord[15] == $past(operatingModeWord[15]))
	else $error("loop flag not nesting bit");
count_down_a: assert property (lastOk && loopCounter != 16'h0001
	|=> loopCounter == $past(loopCounter) - 16'h0001 && !loopEnd) else $error("no decrement");
count_end_a: assert property (lastOk && loopCounter == 16'h0001 |=> loopEnd)
	else $error("loop did not end");
count_load_a: assert property (loopStartCount && !mvWrite |=> loopCounter == $past(loopCountIn)
	&& loopEndAddress == $past(loopEndIn)) else $error("loop start load wrong");
snap_take_a: assert property (fastIrqEnter && !mvWrite |=> fastIrqStateSnapshot ==
	{$past(stackPointerLowBit), $past(coreStatusWord[15]), $past(operatingModeWord[15]),
	$past(coreStatusWord[9:0])}) else $error("snapshot wrong");
ret_take_a: assert property (fastIrqEnter && !mvWrite
	|=> fastIrqReturnAddress == $past(programAddress)) else $error("return address wrong");
call_push_a: assert property (subroutineCall |=> pushValid)
	else $error("no push on call");
// main scenarios
cover property (loopEnd);
cover property (restoreValid);
cover property (pushValid);
endmodule // lfsr_loop_regs_chk
bind lfsr_loop_regs lfsr_loop_regs_chk chk_inst (.*);

// ===== dv/lfsr_tb.sv
// testbench for the loop and fast interrupt state registers
`timescale 1ns/1ps
module tb;
// ============================================================
// stimulus and observed signals
reg clk = 1'b0;
reg nrst = 1'b0;
reg mvWrite = 1'b0, mvRead = 1'b0, mvLong = 1'b0, singleInstructionRepeat = 1'b0;
reg [2:0] mvSel = 3'h0;
reg [31:0] mvWdata = 32'h0;
reg [15:0] pcLow = 16'h1234, operatingModeWord = 16'h0, stackedStatus = 16'h0;
reg [15:0] loopCountIn = 16'h0002;
reg [23:0] loopEndIn = 24'h123456;
reg [4:0] pcHigh = 5'h15;
reg [7:0] ccrIn = 8'h5a;
reg stackPointerLowBit = 1'b1;
reg [9:0] pv = 10'h000; // one-cycle control pulses
wire loopStartCount, loopStartFromCounter, loopLastInstr, nestDone, subroutineCall;
wire subroutineReturn, fastIrqEnter, fastIrqExit, ccrLoad, pcLoad;
assign {pcLoad, ccrLoad, fastIrqExit, fastIrqEnter, subroutineReturn, subroutineCall,
	nestDone, loopLastInstr, loopStartFromCounter, loopStartCount} = pv;
wire [31:0] mvRdata;
wire [15:0] coreStatusWord, pushStatus, loopCounter;
wire [20:0] programAddress, fastIrqReturnAddress;
wire [23:0] loopEndAddress, hwStackTop;
wire [12:0] fastIrqStateSnapshot;
wire pushValid, loopEnd, restoreValid;
integer n_mismatch = 0, tests_run = 0;
lfsr_loop_regs lfsr_loop_regs_inst (.*);
always #25 clk = ~clk;
// ============================================================
// tasks
task chk(input [31:0] got, input [31:0] exp);
	begin
		tests_run = tests_run + 1;
		if (got !== exp)
		begin
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
			n_mismatch = n_mismatch + 1;
		end
	end
endtask
// move access: w=1 write, w=0 read
task mv(input w, input [2:0] s, input l, input [31:0] d);
	begin
		@(negedge clk);
		{mvSel, mvLong, mvWdata, mvWrite, mvRead} = {s, l, d, w, !w};
		@(negedge clk);
		{mvWrite, mvRead} = 2'b00;
	end
endtask
task pl(input [9:0] v);
	begin
		@(negedge clk);
		pv = v;
		@(negedge clk);
		pv = 10'h000;
	end
endtask
task results;
	begin
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
endtask
// ============================================================
// sequence
initial
begin
	repeat (11) @(negedge clk);
	nrst = 1'b1;
	repeat (3) @(negedge clk);
	chk(coreStatusWord, 32'h0300);
	mv(1, 3'h3, 1, 32'hffabcdef);
	mv(0, 3'h3, 1, 0);
	chk(mvRdata, 32'h00abcdef);
	mv(1, 3'h1, 0, 32'h5);
	mv(1, 3'h1, 0, 32'h7);
	mv(0, 3'h2, 0, 0);
	chk(mvRdata, 32'h5);
	operatingModeWord = 16'h8000;
	pl(10'h001);
	chk(loopEndAddress, 32'h123456);
	chk(coreStatusWord[15], 1);
	singleInstructionRepeat = 1'b1;
	pl(10'h004);
	chk(loopCounter, 2);
	singleInstructionRepeat = 1'b0;
	pl(10'h004);
	chk(loopCounter, 1);
	pl(10'h004);
	chk(loopEnd, 1);
	chk(loopCounter, 7);
	chk(coreStatusWord[15], 1);
	pl(10'h008);
	chk(loopEndAddress, 32'habcdef);
	operatingModeWord = 16'h0;
	mv(1, 3'h1, 0, 32'h1);
	pl(10'h002);
	chk(coreStatusWord[15], 1);
	pl(10'h004);
	chk({loopEnd, coreStatusWord[15]}, 2'b10);
	mv(1, 3'h5, 1, 32'haabbccdd);
	chk({coreStatusWord[15], hwStackTop}, 32'h1bbccdd);
	mv(0, 3'h5, 1, 0);
	chk(mvRdata, 32'h00bbccdd);
	chk(hwStackTop, 32'h0);
	chk(coreStatusWord[15], 0);
	mv(1, 3'h0, 0, 32'h7c00);
	chk(coreStatusWord[14:10], 0);
	pl(10'h200);
	chk(programAddress, 32'h151234);
	pl(10'h010);
	chk({pushValid, pushStatus[14:10]}, 6'h35);
	stackedStatus = 16'h2800;
	pl(10'h020);
	chk(coreStatusWord[14:10], 32'h0a);
	pl(10'h100);
	mv(0, 3'h0, 0, 0);
	chk(mvRdata & 32'hffff83ff, 32'h005a);
	pl(10'h040);
	chk(fastIrqReturnAddress, 32'h0a1234);
	chk(fastIrqStateSnapshot, 32'h105a);
	mv(1, 3'h0, 0, 32'h83ff);
	pl(10'h200);
	pl(10'h080);
	chk(restoreValid, 1);
	chk(coreStatusWord, 32'h285a);
	nrst = 1'b0;
	repeat (2) @(negedge clk);
	nrst = 1'b1;
	repeat (3) @(negedge clk);
	chk(fastIrqReturnAddress, 32'h0a1234);
	chk(fastIrqStateSnapshot, 32'h105a);
	chk(coreStatusWord[15], 0);
	results;
end
// hang guard
initial
begin
	#1000000;
	n_mismatch = n_mismatch + 1;
	results;
end
endmodule // tb
